// *** include/abdma_pkg.sv ***
// Purpose: constants of the bus fabric: address map, slave codes, resets
// Assumes: 32-bit byte addresses, half-open ranges [base, limit)
// Notes: used by the fabric module; the bench repeats the map values itself
package abdma_pkg;
	// boot region, remapped
	localparam logic [31:0] BOOT_BASE     = 32'h0000_0000;
	localparam logic [31:0] BOOT_LIMIT    = 32'h0400_0000;
	// memories
	localparam logic [31:0] ROM_BASE      = 32'h07f0_0000;
	localparam logic [31:0] ROM_LIMIT     = 32'h07f2_8000;
	localparam logic [31:0] OTPREG_BASE   = 32'h07f4_0000;
	localparam logic [31:0] OTPREG_LIMIT  = 32'h07f4_0100;
	localparam logic [31:0] OTPCELL_BASE  = 32'h07f8_0000;
	localparam logic [31:0] OTPCELL_LIMIT = 32'h07f8_3000;
	localparam logic [31:0] RAM_BASE      = 32'h07fc_0000;
	localparam logic [31:0] RAM2_BASE     = 32'h07fc_8000;
	localparam logic [31:0] RAM_LIMIT     = 32'h07fd_0000;
	// link layer registers, radio power domain
	localparam logic [31:0] LINK_BASE     = 32'h4000_0000;
	localparam logic [31:0] LINK_LIMIT    = 32'h4000_1000;
	// narrow bridge windows
	localparam logic [31:0] PMU_BASE      = 32'h5000_0000;
	localparam logic [31:0] WKUP_BASE     = 32'h5000_0100;
	localparam logic [31:0] QDEC_BASE     = 32'h5000_0200;
	localparam logic [31:0] QDEC_LIMIT    = 32'h5000_0300;
	localparam logic [31:0] SER1_BASE     = 32'h5000_1000;
	localparam logic [31:0] SER2_BASE     = 32'h5000_1100;
	localparam logic [31:0] SPI_BASE      = 32'h5000_1200;
	localparam logic [31:0] I2C_BASE      = 32'h5000_1300;
	localparam logic [31:0] I2C_LIMIT     = 32'h5000_1400;
	// wide bridge windows, timers power domain
	localparam logic [31:0] TIM1_BASE     = 32'h5000_4000;
	localparam logic [31:0] TIM_LIMIT     = 32'h5000_4200;
	// boot remap encodings
	localparam logic [1:0]  REMAP_ROM     = 2'h0;
	localparam logic [1:0]  REMAP_OTP     = 2'h1;
	localparam logic [1:0]  REMAP_RAM     = 2'h2;
	// bus priority: 0 processor first, 1 dma first
	localparam logic        PRIO_RESET    = 1'h0;
	// slave select one-hot positions
	localparam int SEL_ROM     = 0;
	localparam int SEL_OTPREG  = 1;
	localparam int SEL_OTPCELL = 2;
	localparam int SEL_RAM1    = 3;
	localparam int SEL_RAM2    = 4;
	localparam int SEL_LINK    = 5;
	localparam int SEL_NARROW  = 6;
	localparam int SEL_WIDE    = 7;
	localparam int SEL_W       = 8;
	// grant codes
	typedef enum logic [1:0] {
		GNT_NONE = 2'b00,
		GNT_CPU  = 2'b01,
		GNT_DMA  = 2'b10
	} abdma_gnt_t;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_DATA  = 2'b01,
		ST_ERR1  = 2'b10,
		ST_ERR2  = 2'b11
	} abdma_st_t;
endpackage

// *** tb/abdma_slave_model.sv ***
// Purpose: slave side model answering the fabric's selects
// Assumes: one ready per selected access, after dly wait cycles
// Notes: slv_err is junk outside ready, as on a real slave
`timescale 1ns/10ps
`default_nettype none
module abdma_slave_model (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// bench controls
	input  wire logic [1:0] dly,
	input  wire logic       err_en,
	// fabric side
	input  wire logic [7:0] slv_sel,
	output logic            slv_ready,
	output logic            slv_err
);
	logic [1:0] cnt_ff;
	// one ready pulse per access; cleared so a held select is not answered twice
	always_ff @(posedge sys_clk) begin
		if (!rst_n || slv_sel == 8'h00 || slv_ready) begin
			cnt_ff    <= 2'h0;
			slv_ready <= 1'b0;
		end else if (cnt_ff == dly) begin
			slv_ready <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
		end
	end
	// error only means something with ready
	assign slv_err = slv_ready ? err_en : ~cnt_ff[0];
endmodule
`default_nettype wire

// *** tb/ahb_apb_decode_and_master_arbiter_tb.sv ***
// Purpose: self-checking bench of the bus fabric
// Assumes: slave model answers every selected access
// Notes: map corners plus seeded random traffic
`timescale 1ns/10ps
`default_nettype none
module ahb_apb_decode_and_master_arbiter_tb;
	logic        sys_clk, rst_n, prio, cpu_req, dma_req, slv_ready, slv_err, err_en;
	logic        cpu_gnt, dma_gnt, xfer_done, xfer_err, c, d, wd, fin;
	logic [1:0]  remap, dly;
	logic [7:0]  slv_sel, es;
	logic [31:0] cpu_addr, dma_addr, slv_addr, a;
	int          bad_count, num_checks, seed, i, n;
	logic [31:0] corn [17] = '{32'h0400_0000, 32'h07f2_7fff, 32'h07f2_8000, 32'h07f4_0000,
		32'h07f4_0100, 32'h07f8_2fff, 32'h07fc_7fff, 32'h07fc_8000, 32'h07fd_0000,
		32'h4000_0fff, 32'h4000_1000, 32'h5000_02ff, 32'h5000_0300, 32'h5000_13ff,
		32'h5000_1400, 32'h5000_41ff, 32'h5000_4200};
	abdma_fabric i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_priority_select(prio),
		.boot_remap_select(remap), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .dma_req(dma_req),
		.dma_addr(dma_addr), .slv_ready(slv_ready), .slv_err(slv_err), .cpu_gnt(cpu_gnt),
		.dma_gnt(dma_gnt), .xfer_done(xfer_done), .xfer_err(xfer_err), .slv_addr(slv_addr),
		.slv_sel(slv_sel));
	abdma_slave_model i_slv (.sys_clk(sys_clk), .rst_n(rst_n), .dly(dly), .err_en(err_en),
		.slv_sel(slv_sel), .slv_ready(slv_ready), .slv_err(slv_err));
	// clock, 25 ns period
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	function automatic logic in_rng(input logic [31:0] x, lo, hi);
		return x >= lo && x < hi;
	endfunction
	// expected one-hot select from the address map and remap code
	function automatic logic [7:0] exp_sel(input logic [31:0] x);
		if (x < 32'h0400_0000)
			return remap == 2'h0 ? 8'h01 : remap == 2'h1 ? 8'h04 : remap == 2'h2 ? 8'h08 : 8'h00;
		return in_rng(x, 32'h07f0_0000, 32'h07f2_8000) ? 8'h01 :
			in_rng(x, 32'h07f4_0000, 32'h07f4_0100) ? 8'h02 :
			in_rng(x, 32'h07f8_0000, 32'h07f8_3000) ? 8'h04 :
			in_rng(x, 32'h07fc_0000, 32'h07fc_8000) ? 8'h08 :
			in_rng(x, 32'h07fc_8000, 32'h07fd_0000) ? 8'h10 :
			in_rng(x, 32'h4000_0000, 32'h4000_1000) ? 8'h20 :
			in_rng(x, 32'h5000_0000, 32'h5000_0300) ? 8'h40 :
			in_rng(x, 32'h5000_1000, 32'h5000_1400) ? 8'h40 :
			in_rng(x, 32'h5000_4000, 32'h5000_4200) ? 8'h80 : 8'h00;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, seen);
			bad_count++;
		end
	endtask
	task automatic stop_test();
		if (bad_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// one transfer; masters drop req at the edge that brings done
	task automatic xfer(input logic rc, rd, input logic [31:0] ra);
		@(posedge sys_clk);
		cpu_req <= rc;
		dma_req <= rd;
		cpu_addr <= ra;
		dma_addr <= ra;
		dly <= 2'($random(seed));
		err_en <= ($random(seed) & 7) == 0;
		@(posedge sys_clk);
		#1;
		wd = rd & (~rc | prio);
		es = exp_sel(ra);
		chk("grant", {cpu_gnt, dma_gnt}, {~wd, wd});
		chk("select", slv_sel, es);
		chk("address", slv_addr, ra);
		for (n = 0; n < 20 && !xfer_done; n++) begin
			fin = (slv_ready && slv_sel != 8'h00) || xfer_err;
			@(posedge sys_clk);
			if (fin) begin
				cpu_req <= 1'b0;
				dma_req <= 1'b0;
			end
			#1;
		end
		chk("latency", n, es == 8'h00 ? 2 : dly + 2);
		chk("done", xfer_done, 1'b1);
		chk("error", xfer_err, es == 8'h00 || err_en);
		chk("release", {cpu_gnt, dma_gnt, slv_sel}, 10'h000);
	endtask
	// main sequence: reset, priority, remap codes, corners, random mix
	initial begin
		seed = 32'hc4c9;
		bad_count = 0;
		num_checks = 0;
		{rst_n, prio, cpu_req, dma_req, err_en, remap, dly} = '0;
		cpu_addr = '0;
		dma_addr = '0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		chk("reset", {cpu_gnt, dma_gnt, xfer_done, xfer_err, slv_sel}, 12'h000);
		for (i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			prio <= i[0];
			xfer(1'b1, 1'b1, 32'h07fc_8000);
			xfer(1'b0, 1'b1, 32'h5000_4000);
		end
		for (i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			remap <= i[1:0];
			xfer(1'b1, 1'b0, 32'h0000_0100);
		end
		for (i = 0; i < 17; i++)
			xfer(1'b1, 1'b0, corn[i]);
		for (i = 0; i < 60; i++) begin
			@(posedge sys_clk);
			{prio, remap, c, d} <= 5'($random(seed));
			a = corn[$unsigned($random(seed)) % 17] + 32'($random(seed) & 32'h1ff) - 32'h100;
			@(posedge sys_clk);
			xfer(c, d | ~c, a);
		end
		stop_test();
	end
	// watchdog against a hung handshake
	initial begin
		#(25 * 5000);
		bad_count++;
		stop_test();
	end
endmodule
`default_nettype wire

// *** verilog/abdma_fabric.sv ***
// Purpose: master arbiter and address decoder of the system bus
// Assumes: single-beat requests held until granted; slaves answer with ready/resp
// Notes:
// Contract
// - at most one master granted at once
// - priority select level, processor first while it is low
// - processor or dma master; memories are slaves
// - boot region remapped to rom, otp or ram
// - rom window decoded
// - otp control register window decoded
// - otp cell array window decoded
// - 64 kB ram in two 32 kB banks
// - link-layer register window over ahb
// - pmu and clock window on narrow bridge
// - wake-up window on narrow bridge
// - step-counter window on narrow bridge
// - first serial port on narrow bridge
// - second serial port on narrow bridge
// - spi window on narrow bridge
// - i2c window on narrow bridge
// - timers reached via wide bridge
// - narrow bridge serves system peripherals; link layer has its own select
`timescale 1ns/10ps
`default_nettype none
module abdma_fabric (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// configuration levels
	input  wire logic        bus_priority_select,
	input  wire logic [1:0]  boot_remap_select,
	// processor request
	input  wire logic        cpu_req,
	input  wire logic [31:0] cpu_addr,
	// dma request
	input  wire logic        dma_req,
	input  wire logic [31:0] dma_addr,
	// slave answer
	input  wire logic        slv_ready,
	input  wire logic        slv_err,
	// grant and done back to masters
	output logic             cpu_gnt,
	output logic             dma_gnt,
	output logic             xfer_done,
	output logic             xfer_err,
	// address phase toward slaves
	output logic [31:0]      slv_addr,
	output logic [7:0]       slv_sel
);
	typedef struct packed {
		abdma_pkg::abdma_gnt_t gnt;
		abdma_pkg::abdma_st_t  st;
		logic [31:0]           addr;
		logic [7:0]            sel;
		logic                  done;
		logic                  err;
	} abdma_state_t;

	abdma_state_t st_ff;
	abdma_state_t nxt_st;

	// address decode, used for both masters
	function automatic logic [7:0] abdma_decode(input logic [31:0] a, input logic [1:0] rm);
		logic [7:0] s;
		s = 8'h00;
		if (a < abdma_pkg::BOOT_LIMIT) begin
			case (rm)
				abdma_pkg::REMAP_ROM: s[abdma_pkg::SEL_ROM] = 1'b1;
				abdma_pkg::REMAP_OTP: s[abdma_pkg::SEL_OTPCELL] = 1'b1;
				abdma_pkg::REMAP_RAM: s[abdma_pkg::SEL_RAM1] = 1'b1;
				default: s = 8'h00;
			endcase
		end
		else if (a >= abdma_pkg::ROM_BASE && a < abdma_pkg::ROM_LIMIT)
			s[abdma_pkg::SEL_ROM] = 1'b1;
		else if (a >= abdma_pkg::OTPREG_BASE && a < abdma_pkg::OTPREG_LIMIT)
			s[abdma_pkg::SEL_OTPREG] = 1'b1;
		else if (a >= abdma_pkg::OTPCELL_BASE && a < abdma_pkg::OTPCELL_LIMIT)
			s[abdma_pkg::SEL_OTPCELL] = 1'b1;
		else if (a >= abdma_pkg::RAM_BASE && a < abdma_pkg::RAM2_BASE)
			s[abdma_pkg::SEL_RAM1] = 1'b1;
		else if (a >= abdma_pkg::RAM2_BASE && a < abdma_pkg::RAM_LIMIT)
			s[abdma_pkg::SEL_RAM2] = 1'b1;
		else if (a >= abdma_pkg::LINK_BASE && a < abdma_pkg::LINK_LIMIT)
			s[abdma_pkg::SEL_LINK] = 1'b1;
		else if (a >= abdma_pkg::PMU_BASE && a < abdma_pkg::QDEC_LIMIT)
			s[abdma_pkg::SEL_NARROW] = 1'b1;
		// serial ports; spi; i2c; shared bridge
		else if (a >= abdma_pkg::SER1_BASE && a < abdma_pkg::I2C_LIMIT)
			s[abdma_pkg::SEL_NARROW] = 1'b1;
		else if (a >= abdma_pkg::TIM1_BASE && a < abdma_pkg::TIM_LIMIT)
			s[abdma_pkg::SEL_WIDE] = 1'b1;
		// gaps fall through with no select
		return s;
	endfunction

	// next state: arbitrate when idle, wait for slave, or answer error
	always_comb begin
		logic dma_wins;
		dma_wins = 1'b0;
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		nxt_st.err = 1'b0;
		case (st_ff.st)
			abdma_pkg::ST_IDLE: begin
				dma_wins = dma_req && (!cpu_req || bus_priority_select);
				if (dma_wins) begin
					nxt_st.gnt = abdma_pkg::GNT_DMA;
					nxt_st.addr = dma_addr;
					nxt_st.sel = abdma_decode(dma_addr, boot_remap_select);
				end else if (cpu_req) begin
					nxt_st.gnt = abdma_pkg::GNT_CPU;
					nxt_st.addr = cpu_addr;
					nxt_st.sel = abdma_decode(cpu_addr, boot_remap_select);
				end
				if (dma_wins || cpu_req) begin
					// empty select goes to two-cycle error
					if (nxt_st.sel == 8'h00)
						nxt_st.st = abdma_pkg::ST_ERR1;
					else
						nxt_st.st = abdma_pkg::ST_DATA;
				end
			end
			abdma_pkg::ST_DATA: begin
				if (slv_ready) begin
					nxt_st.st = abdma_pkg::ST_IDLE;
					nxt_st.gnt = abdma_pkg::GNT_NONE;
					nxt_st.sel = 8'h00;
					nxt_st.done = 1'b1;
					nxt_st.err = slv_err;
				end
			end
			abdma_pkg::ST_ERR1: begin
				nxt_st.st = abdma_pkg::ST_ERR2;
				nxt_st.err = 1'b1;
			end
			abdma_pkg::ST_ERR2: begin
				nxt_st.st = abdma_pkg::ST_IDLE;
				nxt_st.gnt = abdma_pkg::GNT_NONE;
				nxt_st.done = 1'b1;
				nxt_st.err = 1'b1;
			end
			default: nxt_st.st = abdma_pkg::ST_IDLE;
		endcase
	end

	// registered state, synchronous reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register; grant codes are one-hot, one flop each
	assign cpu_gnt   = st_ff.gnt[0];
	assign dma_gnt   = st_ff.gnt[1];
	assign xfer_done = st_ff.done;
	assign xfer_err  = st_ff.err;
	assign slv_addr  = st_ff.addr;
	assign slv_sel   = st_ff.sel;

	// checks: arbitration, decode windows, error path
	// never both granted
	a_single_grant: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!(cpu_gnt && dma_gnt))
		else $error("both masters granted");

	// processor first when select is low
	a_prio_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_IDLE && cpu_req && dma_req && !bus_priority_select)
		|=> cpu_gnt)
		else $error("processor lost priority");

	// dma first when select is high
	a_prio_dma: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_IDLE && cpu_req && dma_req && bus_priority_select)
		|=> dma_gnt)
		else $error("dma lost priority");

	a_sel_grant: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(slv_sel != 8'h00) |-> (cpu_gnt || dma_gnt))
		else $error("slave selected without grant");

	a_rom_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::ROM_BASE
		&& slv_addr < abdma_pkg::ROM_LIMIT) |-> slv_sel == 8'h01)
		else $error("rom window missed");

	a_otpreg_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::OTPREG_BASE
		&& slv_addr < abdma_pkg::OTPREG_LIMIT) |-> slv_sel == 8'h02)
		else $error("otp register window missed");

	a_otpcell_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::OTPCELL_BASE
		&& slv_addr < abdma_pkg::OTPCELL_LIMIT) |-> slv_sel == 8'h04)
		else $error("otp cell window missed");

	a_ram_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::RAM_BASE
		&& slv_addr < abdma_pkg::RAM2_BASE) |-> slv_sel == 8'h08)
		else $error("ram bank one missed");

	a_ram_bank: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::RAM2_BASE
		&& slv_addr < abdma_pkg::RAM_LIMIT) |-> slv_sel == 8'h10)
		else $error("ram bank two missed");

	a_link_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::LINK_BASE
		&& slv_addr < abdma_pkg::LINK_LIMIT) |-> slv_sel == 8'h20)
		else $error("link window missed");

	a_pmu_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::PMU_BASE
		&& slv_addr < abdma_pkg::WKUP_BASE) |-> slv_sel == 8'h40)
		else $error("pmu window missed");

	a_wkup_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::WKUP_BASE
		&& slv_addr < abdma_pkg::QDEC_BASE) |-> slv_sel == 8'h40)
		else $error("wake-up window missed");

	a_step_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::QDEC_BASE
		&& slv_addr < abdma_pkg::QDEC_LIMIT) |-> slv_sel == 8'h40)
		else $error("step counter window missed");

	a_ser1_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::SER1_BASE
		&& slv_addr < abdma_pkg::SER2_BASE) |-> slv_sel == 8'h40)
		else $error("first serial window missed");

	a_ser2_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::SER2_BASE
		&& slv_addr < abdma_pkg::SPI_BASE) |-> slv_sel == 8'h40)
		else $error("second serial window missed");

	a_spi_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::SPI_BASE
		&& slv_addr < abdma_pkg::I2C_BASE) |-> slv_sel == 8'h40)
		else $error("spi window missed");

	a_i2c_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::I2C_BASE
		&& slv_addr < abdma_pkg::I2C_LIMIT) |-> slv_sel == 8'h40)
		else $error("i2c window missed");

	// narrow bridge only for its own windows
	a_narrow_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_sel == 8'h40) |->
		((slv_addr >= abdma_pkg::PMU_BASE && slv_addr < abdma_pkg::QDEC_LIMIT)
		|| (slv_addr >= abdma_pkg::SER1_BASE && slv_addr < abdma_pkg::I2C_LIMIT)))
		else $error("narrow bridge selected outside its windows");

	a_wide_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA && slv_addr >= abdma_pkg::TIM1_BASE
		&& slv_addr < abdma_pkg::TIM_LIMIT) |-> slv_sel == 8'h80)
		else $error("timer window missed");

	// error answer two cycles, then done
	a_gap_error: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_ERR1) |-> (slv_sel == 8'h00)
		##1 (xfer_err && !xfer_done) ##1 (xfer_err && xfer_done))
		else $error("gap access not errored");

	// remap to ram selects bank one
	a_remap_ram: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_IDLE && cpu_req && !dma_req
		&& cpu_addr < abdma_pkg::BOOT_LIMIT && boot_remap_select == abdma_pkg::REMAP_RAM)
		|=> slv_sel == 8'h08)
		else $error("boot remap to ram wrong");

	a_remap_rom: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_IDLE && cpu_req && !dma_req
		&& cpu_addr < abdma_pkg::BOOT_LIMIT && boot_remap_select == abdma_pkg::REMAP_ROM)
		|=> slv_sel == 8'h01)
		else $error("boot remap to rom wrong");

	a_remap_otp: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_IDLE && cpu_req && !dma_req
		&& cpu_addr < abdma_pkg::BOOT_LIMIT && boot_remap_select == abdma_pkg::REMAP_OTP)
		|=> slv_sel == 8'h04)
		else $error("boot remap to otp wrong");

	a_remap_none: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_IDLE && cpu_req && !dma_req
		&& cpu_addr < abdma_pkg::BOOT_LIMIT && boot_remap_select == 2'h3)
		|=> (slv_sel == 8'h00 && st_ff.st == abdma_pkg::ST_ERR1))
		else $error("unused remap code not errored");

	// data phase always has a target
	a_data_sel: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_DATA) |-> (slv_sel != 8'h00))
		else $error("data phase with no slave");

	a_idle_free: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_IDLE) |-> (!cpu_gnt && !dma_gnt))
		else $error("grant held while idle");

	// one master owns every busy cycle
	a_busy_grant: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st != abdma_pkg::ST_IDLE) |-> (cpu_gnt || dma_gnt))
		else $error("busy with no grant");

	a_done_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
		xfer_done |=> !xfer_done)
		else $error("done held too long");

	a_done_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
		xfer_done |-> (!cpu_gnt && !dma_gnt && slv_sel == 8'h00))
		else $error("bus not released on done");

	a_err_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_ERR2) |-> (slv_sel == 8'h00 && xfer_err))
		else $error("error phase wrong");

	// lone processor request carries its address
	a_addr_cpu: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_IDLE && cpu_req && !dma_req)
		|=> (cpu_gnt && slv_addr == $past(cpu_addr)))
		else $error("processor address not passed");

	// lone dma request carries its address
	a_addr_dma: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.st == abdma_pkg::ST_IDLE && dma_req && !cpu_req)
		|=> (dma_gnt && slv_addr == $past(dma_addr)))
		else $error("dma address not passed");
endmodule
`default_nettype wire
